// [hdl/reset_warning_power_sequencer.sv]
// Reset, shutdown-warning and power sequencer of the supervisor
// Summary of operation
// RL1 - Reset asserts on power-up, rail undervoltage, shutdown, watchdog, manual reset.
// RL2 - Shutdown-caused reset follows the shutdown timing, not the reset hold.
// RL3 - Config bit 1 selects reset polarity: 0 active low, 1 active high.
// RL4 - Non-watchdog causes hold reset while present; watchdog gives pulses.
// RL5 - Reset releases only after the hold time once a non-shutdown cause is gone.
// RL6 - Warning goes low on battery over/undervoltage or ignition low.
// RL7 - Processor may read fault status on warning low.
// RL8 - Aux follower open-drain output follows aux comparator directly.
// RL9 - Config bit 2 set blocks aux rail undervoltage from causing reset.
// RL10 - Level mode: on at ignition high; off 2 s after ignition low once shutdown ends.
// RL11 - Internal start-up completes within 5 us before supervision.
// RL12 - Ignition off field 1001 selects edge wake; no turn-off on ignition low.
// RL13 - Edge mode powers down only by software request or battery loss.
// RL14 - Lock bit 3 set ignores software power-down requests.
// RL15 - Power-down bit 1 powers down; 0 stays active.
// RL16 - Each register has one address for read and write.
// RL17 - Register defaults load at power-up.
// RL18 - Manual reset has highest priority among reset causes.
// RL19 - Software power-down only requested in edge-sensitive mode; the code also takes the request in level mode.
// RL20 - Hold and turn-off delays counted on internal clock; cause restarts.
`timescale 1ns/10ps
`include "rst_seq_defines.svh"
module reset_warning_power_sequencer #(
  parameter int HOLD_CYC = `HOLD_MS * 1000 * `CLK_MHZ,
  parameter int TURNOFF_CYC = `TURNOFF_MS * 1000 * `CLK_MHZ
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Monitor comparators, high means fault or level true
  input wire logic batteryOvIn,
  input wire logic batteryUvIn,
  input wire logic ignitionAboveOnIn,
  input wire logic ignitionBelowOffIn,
  input wire logic logicRailUvIn,
  input wire logic auxRailUvIn,
  input wire logic batteryPresentIn,
  // Other reset causes
  input wire logic manualRestartInputN,
  input wire logic watchdogFailIn,
  input wire logic powerOffOutputN,
  // Register port
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  // Outputs
  output logic resetOut,
  output logic earlyFaultWarningN,
  output logic auxFollowerOut,
  output logic auxFollowerOe,
  output logic supplyOn
);
  logic [6:0] sa_r, sb_r;
  logic [6:0] syn;
  logic mrN_r, mrNs_r;
  logic [7:0] ignOff_r, rstCfg_r, swPd_r, sfLock_r;
  logic [2:0] faultLatch_r;
  rst_seq_pkg::pwr_state_t pwr_r;
  logic [31:0] startCnt_r, offCnt_r, holdCnt_r;
  logic [15:0] wdCnt_r;
  logic resetAct_r;
  logic edgeMode, running, holdCause, wdPulse;
  logic sdnRun, pdReq;

  // Monitor comparator pins and manual reset pass two flops before use; watchdog, shutdown and aux follower pins do not
  always_ff @(posedge ref_clk)
  begin
    sa_r <= {batteryOvIn, batteryUvIn, ignitionAboveOnIn, ignitionBelowOffIn,
             logicRailUvIn, auxRailUvIn, batteryPresentIn};
    sb_r <= sa_r;
    mrN_r <= manualRestartInputN;
    mrNs_r <= mrN_r;
  end
  assign syn = sb_r;
  // syn: 6 ov, 5 uv, 4 ign on, 3 ign below off, 2 logic uv, 1 aux uv, 0 batt

  assign edgeMode = ignOff_r[`FLD_IGN_OFF_HI:`FLD_IGN_OFF_LO] ==
                    `EDGE_MODE_CODE; // RL12
  assign running = pwr_r == rst_seq_pkg::PWR_RUN;
  assign pdReq = swPd_r[`BIT_PD_REQ] && !sfLock_r[`BIT_PD_LOCK]; // RL14 RL15
  assign sdnRun = running && powerOffOutputN;

  // Register file, one address per register for both directions
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      ignOff_r <= `RST_DEF_IGN_OFF; // RL17
      rstCfg_r <= `RST_DEF_RST_CFG;
      swPd_r <= `RST_DEF_SW_PD;
      sfLock_r <= `RST_DEF_SF_LOCK;
    end
    else if (regWrite)
    begin
      unique case (regAddr) // RL16
        `OFS_IGN_OFF: ignOff_r <= regWdata;
        `OFS_RST_CFG: rstCfg_r <= regWdata;
        `OFS_SW_PD: swPd_r <= {7'h00, regWdata[`BIT_PD_REQ]};
        // Lock bits only set; a power cycle clears them
        `OFS_SF_LOCK: sfLock_r <= sfLock_r | regWdata;
        default: ;
      endcase
    end
  end

  // Edge fault record since the last read: 4 uv, 5 ov, 6 ignition below off
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      faultLatch_r <= 3'h4;
    else if (regRead && regAddr == `OFS_FAULT)
      faultLatch_r <= {syn[3], syn[6], syn[5]}; // set wins over clear
    else
      faultLatch_r <= faultLatch_r | {syn[3], syn[6], syn[5]};
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      regRdata <= 8'h00;
    else
    begin
      unique case (regAddr)
        `OFS_IGN_OFF: regRdata <= ignOff_r;
        `OFS_RST_CFG: regRdata <= rstCfg_r;
        `OFS_SW_PD: regRdata <= swPd_r;
        `OFS_SF_LOCK: regRdata <= sfLock_r;
        `OFS_FAULT: regRdata <= {1'b0, faultLatch_r, syn[6], syn[5],
                                 syn[4], syn[3]}; // RL7
        default: regRdata <= 8'h00;
      endcase
    end
  end

  // Power sequencing
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      pwr_r <= rst_seq_pkg::PWR_OFF;
      startCnt_r <= 32'h0;
      offCnt_r <= 32'h0;
    end
    else if (!syn[0])
    begin
      pwr_r <= rst_seq_pkg::PWR_OFF; // RL13
      offCnt_r <= 32'h0;
    end
    else
    begin
      unique case (pwr_r)
        rst_seq_pkg::PWR_OFF:
          if (syn[4]) // RL10
          begin
            pwr_r <= rst_seq_pkg::PWR_START;
            startCnt_r <= 32'h0;
          end
        rst_seq_pkg::PWR_START:
          if (startCnt_r == `STARTUP_CYC - 1) // RL11
            pwr_r <= rst_seq_pkg::PWR_RUN;
          else
            startCnt_r <= startCnt_r + 32'h1;
        rst_seq_pkg::PWR_RUN:
          if (pdReq) // RL15
            pwr_r <= rst_seq_pkg::PWR_OFF;
          else if (edgeMode || !syn[3] || !powerOffOutputN)
            offCnt_r <= 32'h0; // RL12 RL20
          else if (offCnt_r == TURNOFF_CYC - 1) // RL10
          begin
            pwr_r <= rst_seq_pkg::PWR_OFF;
            offCnt_r <= 32'h0;
          end
          else
            offCnt_r <= offCnt_r + 32'h1;
        default: pwr_r <= rst_seq_pkg::PWR_OFF;
      endcase
    end
  end

  // Held causes; manual reset leads the list and needs nothing else
  assign holdCause = !mrNs_r // RL18
                     || !running || syn[2] // RL1
                     || (syn[1] && !rstCfg_r[`BIT_AUX_BLOCK]) // RL9
                     || !powerOffOutputN; // RL2
  // Shutdown's own hold/delay already shapes its release: no extra hold
  // Watchdog failure yields fixed-length pulses
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      wdCnt_r <= 16'h0;
    else if (wdCnt_r != 16'h0)
      wdCnt_r <= wdCnt_r - 16'h1;
    else if (watchdogFailIn && sdnRun && !resetAct_r)
      wdCnt_r <= `WD_PULSE_CYC; // RL4
  end
  assign wdPulse = wdCnt_r != 16'h0;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      resetAct_r <= 1'b1;
      holdCnt_r <= 32'h0;
    end
    else if (holdCause && (powerOffOutputN || !mrNs_r || syn[2]))
    begin
      resetAct_r <= 1'b1; // RL4
      holdCnt_r <= HOLD_CYC; // RL20
    end
    else if (holdCause)
    begin
      resetAct_r <= 1'b1; // RL2
      holdCnt_r <= 32'h0;
    end
    else if (holdCnt_r != 32'h0)
      holdCnt_r <= holdCnt_r - 32'h1; // RL5
    else
      resetAct_r <= wdPulse;
  end

  // Outputs
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      resetOut <= 1'b0;
      earlyFaultWarningN <= 1'b1;
      auxFollowerOe <= 1'b0;
      supplyOn <= 1'b0;
    end
    else
    begin
      resetOut <= resetAct_r ~^ rstCfg_r[`BIT_RST_POL]; // RL3
      earlyFaultWarningN <= !(syn[6] || syn[5] || syn[3]); // RL6
      auxFollowerOe <= auxRailUvIn; // RL8
      supplyOn <= pwr_r != rst_seq_pkg::PWR_OFF;
    end
  end
  assign auxFollowerOut = 1'b0;

  chk_ign_low_warn: assert property (@(posedge ref_clk) disable iff (rst)
    syn[3] |=> !earlyFaultWarningN) // RL6
    else $error("warning not low on ignition low");
  chk_pol_follow: assert property (@(posedge ref_clk) disable iff (rst)
    (resetAct_r && !rstCfg_r[1]) |=> !resetOut) // RL3
    else $error("active-low reset wrong");
  chk_mr_reset: assert property (@(posedge ref_clk) disable iff (rst)
    !mrNs_r |=> resetAct_r) // RL18
    else $error("manual reset ignored");
  chk_pd_locked: assert property (@(posedge ref_clk) disable iff (rst)
    (running && sfLock_r[3] && syn[0] && edgeMode) |=> running) // RL14
    else $error("locked power-down taken");
  chk_pd_go: assert property (@(posedge ref_clk) disable iff (rst)
    (running && pdReq && syn[0]) |=> !running) // RL15
    else $error("power-down not taken");
  chk_edge_stay: assert property (@(posedge ref_clk) disable iff (rst)
    (running && edgeMode && !pdReq && syn[0]) |=> running) // RL12
    else $error("edge mode turned off");
  chk_batt_loss: assert property (@(posedge ref_clk) disable iff (rst)
    !syn[0] |=> !running) // RL13
    else $error("battery loss ignored");
  chk_hold_keep: assert property (@(posedge ref_clk) disable iff (rst)
    (!holdCause && holdCnt_r > 32'h1) |=> resetAct_r) // RL5
    else $error("reset released early");
  chk_aux_block: assert property (@(posedge ref_clk) disable iff (rst)
    (holdCause && mrNs_r && running && !syn[2] && powerOffOutputN)
      |-> (syn[1] && !rstCfg_r[2])) // RL9
    else $error("aux cause not gated");

  // A watchdog pulse starts only from a released, running supervisor
  sequence wdStart;
    watchdogFailIn && sdnRun && !resetAct_r && wdCnt_r == 16'h0;
  endsequence
  sequence wdRunning;
    wdPulse ##1 resetAct_r;
  endsequence
  chk_wd_pulse: assert property (@(posedge ref_clk) disable iff (rst)
    wdStart |=> wdRunning) // RL4
    else $error("watchdog pulse missing");
  chk_startup_len: assert property (@(posedge ref_clk) disable iff (rst)
    (pwr_r == rst_seq_pkg::PWR_START && syn[0] &&
     startCnt_r == `STARTUP_CYC - 1) |=> running) // RL11
    else $error("start-up did not end on time");
  chk_power_off_output_reset: assert property (@(posedge ref_clk) disable iff (rst)
    !powerOffOutputN |=> resetAct_r) // RL1
    else $error("shutdown did not assert reset");
  chk_warn_clear: assert property (@(posedge ref_clk) disable iff (rst)
    !(syn[6] || syn[5] || syn[3]) |=> earlyFaultWarningN) // RL6
    else $error("warning low without fault");
  chk_aux_oe: assert property (@(posedge ref_clk) disable iff (rst)
    auxRailUvIn |=> auxFollowerOe) // RL8
    else $error("aux follower not driven");
endmodule

// [hdl/rst_seq_defines.svh]
// Offsets, field positions, reset values and timing counts of the sequencer
`ifndef RST_SEQ_DEFINES_SVH
`define RST_SEQ_DEFINES_SVH
`define OFS_IGN_OFF 8'h04
`define OFS_RST_CFG 8'h0d
`define OFS_SW_PD 8'h17
`define OFS_SF_LOCK 8'h18
`define OFS_FAULT 8'h19
`define BIT_RST_POL 1
`define BIT_AUX_BLOCK 2
`define BIT_PD_LOCK 3
`define BIT_PD_REQ 0
`define FLD_IGN_OFF_HI 4
`define FLD_IGN_OFF_LO 1
`define EDGE_MODE_CODE 4'h9
`define RST_DEF_IGN_OFF 8'h00
`define RST_DEF_RST_CFG 8'h00
`define RST_DEF_SW_PD 8'h00
`define RST_DEF_SF_LOCK 8'h00
`define CLK_MHZ 250
`define STARTUP_US 5
`define STARTUP_CYC (`STARTUP_US * `CLK_MHZ)
`define HOLD_MS 200
`define TURNOFF_MS 2000
`define WD_PULSE_CYC 16'h0100
`endif

// [hdl/rst_seq_pkg.sv]
// Types shared by the sequencer
package rst_seq_pkg;
  typedef enum logic [1:0] {
    PWR_OFF = 2'b00,
    PWR_START = 2'b01,
    PWR_RUN = 2'b10
  } pwr_state_t;
endpackage

// [verif/host_cpu_model.sv]
// Processor model driving the register port of the sequencer
`timescale 1ns/10ps
module host_cpu_model (
  // Clock
  input wire logic ref_clk,
  // Register port
  output logic regWrite,
  output logic regRead,
  output logic [7:0] regAddr,
  output logic [7:0] regWdata,
  input wire logic [7:0] regRdata
);
  initial
  begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 8'h00;
    regWdata = 8'h00;
  end
  // Released data is inverted so a stale byte never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr = a;
    regWdata = d;
    regWrite = 1'b1;
    @(posedge ref_clk);
    #1 regWrite = 1'b0;
    regWdata = ~d;
    // One idle edge so a following write never re-raises the strobe at once
    @(posedge ref_clk);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    regAddr = a;
    regRead = 1'b1;
    @(posedge ref_clk);
    #1 regRead = 1'b0;
    @(posedge ref_clk);
    #1 d = regRdata;
  endtask
endmodule

// [verif/reset_warning_power_sequencer_tb_top.sv]
// Self-checking bench of the reset and power sequencer
`timescale 1ns/10ps
module reset_warning_power_sequencer_tb_top;
  // Short counts keep the run brief
  localparam int HOLD = 20;
  localparam int OFFC = 40;
  logic ref_clk, rst, batOv, batUv, ignOn, ignOff, logicUv, auxUv;
  logic batPres, mrN, wdFail, shdnN, regWrite, regRead;
  logic resetOut, warnN, auxOut, auxOe, supplyOn;
  logic [7:0] regAddr, regWdata, regRdata, rv;
  int badCount, samplesChecked, cycles;
  reset_warning_power_sequencer #(.HOLD_CYC(HOLD), .TURNOFF_CYC(OFFC)) u_dut (
    .ref_clk(ref_clk), .rst(rst), .batteryOvIn(batOv), .batteryUvIn(batUv),
    .ignitionAboveOnIn(ignOn), .ignitionBelowOffIn(ignOff),
    .logicRailUvIn(logicUv), .auxRailUvIn(auxUv), .batteryPresentIn(batPres),
    .manualRestartInputN(mrN), .watchdogFailIn(wdFail),
    .powerOffOutputN(shdnN), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
    .resetOut(resetOut), .earlyFaultWarningN(warnN), .auxFollowerOut(auxOut),
    .auxFollowerOe(auxOe), .supplyOn(supplyOn));
  host_cpu_model u_host (.ref_clk(ref_clk), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
    .regRdata(regRdata));
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      badCount++;
      tally_and_finish();
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      badCount++;
      $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic do_reset();
    rst = 1'b1;
    step(16);
    rst = 1'b0;
  endtask
  task automatic power_up();
    ignOff = 1'b0;
    ignOn = 1'b1;
    step(5);
    check(8'(supplyOn), 8'h01);
    check(8'(resetOut), 8'h00);
    step(1240);
    check(8'(resetOut), 8'h00);
    step(40);
    check(8'(resetOut), 8'h01);
    $display("power up done");
  endtask
  task automatic t_regs();
    u_host.rd(8'h0d, rv);
    check(rv, 8'h00);
    u_host.wr(8'h20, 8'h5a);
    u_host.rd(8'h20, rv);
    check(rv, 8'h00);
    $display("register test done");
  endtask
  task automatic t_polarity();
    u_host.wr(8'h0d, 8'h02);
    step(3);
    check(8'(resetOut), 8'h00);
    u_host.rd(8'h0d, rv);
    check(rv, 8'h02);
    mrN = 1'b0;
    step(5);
    check(8'(resetOut), 8'h01);
    mrN = 1'b1;
    step(10);
    logicUv = 1'b1;
    step(3);
    logicUv = 1'b0;
    step(15);
    check(8'(resetOut), 8'h01);
    step(15);
    check(8'(resetOut), 8'h00);
    u_host.wr(8'h0d, 8'h00);
    $display("polarity test done");
  endtask
  task automatic t_aux();
    auxUv = 1'b1;
    step(5);
    check({6'h00, auxOut, auxOe}, 8'h01);
    check(8'(resetOut), 8'h00);
    auxUv = 1'b0;
    step(HOLD + 10);
    u_host.wr(8'h0d, 8'h04);
    auxUv = 1'b1;
    step(5);
    check({6'h00, auxOe, resetOut}, 8'h03);
    auxUv = 1'b0;
    step(2);
    check(8'(auxOe), 8'h00);
    u_host.wr(8'h0d, 8'h00);
    $display("aux test done");
  endtask
  task automatic t_power_off_output_wd();
    shdnN = 1'b0;
    step(3);
    check(8'(resetOut), 8'h00);
    shdnN = 1'b1;
    step(4);
    check(8'(resetOut), 8'h01);
    wdFail = 1'b1;
    step(3);
    wdFail = 1'b0;
    check(8'(resetOut), 8'h00);
    step(200);
    check(8'(resetOut), 8'h00);
    step(100);
    check(8'(resetOut), 8'h01);
    $display("shutdown and watchdog test done");
  endtask
  task automatic t_level_off();
    batUv = 1'b1;
    step(4);
    check(8'(warnN), 8'h00);
    u_host.rd(8'h19, rv);
    check(rv & 8'h0f, 8'h06);
    batUv = 1'b0;
    batOv = 1'b1;
    step(4);
    check(8'(warnN), 8'h00);
    batOv = 1'b0;
    ignOn = 1'b0;
    ignOff = 1'b1;
    step(20);
    check({6'h00, warnN, supplyOn}, 8'h01);
    step(40);
    check({6'h00, resetOut, supplyOn}, 8'h00);
    $display("level turn-off test done");
  endtask
  task automatic t_edge();
    u_host.wr(8'h04, 8'h12);
    ignOn = 1'b0;
    ignOff = 1'b1;
    step(OFFC + 30);
    check(8'(supplyOn), 8'h01);
    u_host.wr(8'h18, 8'h08);
    u_host.wr(8'h17, 8'h01);
    step(4);
    check(8'(supplyOn), 8'h01);
    do_reset();
    power_up();
    u_host.wr(8'h04, 8'h12);
    ignOn = 1'b0;
    ignOff = 1'b1;
    u_host.wr(8'h17, 8'h01);
    step(4);
    check(8'(supplyOn), 8'h00);
    u_host.wr(8'h17, 8'h00);
    power_up();
    batPres = 1'b0;
    step(5);
    check(8'(supplyOn), 8'h00);
    $display("edge mode test done");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samplesChecked, badCount);
    if (badCount == 0 && samplesChecked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    {rst, batPres, mrN, shdnN} = 4'hf;
    {batOv, batUv, ignOn, ignOff, logicUv, auxUv, wdFail} = 7'h00;
    badCount = 0;
    samplesChecked = 0;
    cycles = 0;
    step(16);
    rst = 1'b0;
    t_regs();
    power_up();
    t_polarity();
    t_aux();
    t_power_off_output_wd();
    t_level_off();
    power_up();
    t_edge();
    tally_and_finish();
  end
endmodule
